// file: design/cmp_prioritizer_top.sv
// Message storage, register access and transmit selection of a CAN controller.
// Assumes a bit engine outside that asks for a frame before SOF, reports ends,
// and hands over checked received frames; CPU bus is synchronous byte access.
//
// How it works
// - Buffers hold 11-bit or 29-bit identifiers
// - Identifier MSB sits at top, sent first
// - Smaller identifier value wins bus arbitration
// - Standard layout: bytes 0,1 with RTR, IDE=0
// - SRR written 1 by software; received SRR stored
// - IDE selects 11-bit or 29-bit format
// - RTR: 0 data frame, 1 remote frame
// - Length code is binary count 0 to 8
// - Remote frame sends code, zero data bytes
// - Eight data bytes, count follows length code
// - Slot 4 receive, slots 5-7 transmit 0-2
// - Transmit buffers have priority byte at D
// - Smallest local priority is highest internal
// - Pick lowest priority pending buffer before SOF
// - Tie goes to lowest buffer index
// - Stop-in-wait bit gates clock in wait
// - Receive buffer read-only; transmit buffers read-write
// - Soft reset aborts transfer, drops sync immediately
`timescale 1ns/1ps
module cmp_prioritizer_top (
   input wire logic clock_i,
   input wire logic reset_i,
   // CPU byte bus
   input wire logic [cmp_pkg::CMP_ADDR_W-1:0] addr_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [cmp_pkg::CMP_DATA_W-1:0] wdata_i,
   output logic [cmp_pkg::CMP_DATA_W-1:0] rdata_o,
   output logic rvalid_o,
   // Transmit side toward the bit engine
   input wire logic [cmp_pkg::CMP_NUM_TX-1:0] tx_buffer_empty_flag_i,
   input wire logic tx_sof_req_i,
   input wire logic tx_end_i,
   output logic tx_valid_o,
   output logic [1:0] tx_buf_o,
   output logic [cmp_pkg::CMP_EXT_ID_W-1:0] tx_id_o,
   output logic tx_ide_o,
   output logic tx_srr_o,
   output logic tx_rtr_o,
   output logic [3:0] tx_dlc_o,
   output logic [3:0] tx_count_o,
   output logic [cmp_pkg::CMP_DATA_BYTES*8-1:0] tx_data_o,
   // Receive side from the bit engine
   input wire logic rx_done_i,
   input wire logic rx_ok_i,
   input wire logic [cmp_pkg::CMP_EXT_ID_W-1:0] rx_id_i,
   input wire logic rx_ide_i,
   input wire logic rx_srr_i,
   input wire logic rx_rtr_i,
   input wire logic [3:0] rx_dlc_i,
   input wire logic [cmp_pkg::CMP_DATA_BYTES*8-1:0] rx_data_i,
   // Status from and control toward the rest of the controller
   input wire logic bus_sync_i,
   input wire logic sleep_ack_i,
   input wire logic wait_mode_i,
   output logic link_reset_o,
   output logic module_clk_en_o,
   output logic timer_link_enable_o,
   output logic sleep_request_o
);
   import cmp_pkg::*;

   // Control register bits
   logic stop_in_wait_r;
   logic bus_synced_r;
   logic timer_link_enable_r;
   logic sleep_ack_r;
   logic sleep_request_r;
   logic soft_reset_bit_r;

   // Message storage: index 0 receive, 1..3 transmit
   logic [7:0] buf_mem [0:CMP_NUM_BUF-1][0:CMP_BUF_BYTES-1];
   logic [CMP_PRIO_W-1:0] prio_mem [0:CMP_NUM_TX-1];

   // Transmit hand-over registers
   logic tx_valid_r;
   logic [1:0] tx_buf_r;
   logic [CMP_EXT_ID_W-1:0] tx_id_r;
   logic tx_ide_r;
   logic tx_srr_r;
   logic tx_rtr_r;
   logic [3:0] tx_dlc_r;
   logic [3:0] tx_count_r;
   logic [CMP_DATA_BYTES*8-1:0] tx_data_r;

   // Bus response registers
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic rvalid_r;
   logic module_clk_en_r;

   // Address decode
   logic in_block;
   logic [2:0] slot;
   logic [3:0] byte_sel;
   logic is_buf;
   logic [1:0] buf_idx;
   logic is_mcr0;
   logic buf_wr;
   logic prio_wr;
   logic mcr0_wr;
   logic rx_store;
   logic [3:0] rx_count;

   // Selector wiring
   logic [CMP_NUM_TX*CMP_PRIO_W-1:0] prio_flat;
   logic win_valid;
   logic [1:0] win_idx;

   // Decoded fields of the winning buffer
   logic [7:0] w_b0;
   logic [7:0] w_b1;
   logic [7:0] w_b2;
   logic [7:0] w_b3;
   logic [7:0] w_len;
   logic w_ide;
   logic w_rtr;
   logic [CMP_EXT_ID_W-1:0] w_id;
   logic [3:0] w_count;
   logic [CMP_DATA_BYTES*8-1:0] w_data;

   // Returns a length code limited to the eight data bytes
   function automatic logic [3:0] clamp_count(input logic [3:0] code);
      clamp_count = (code > CMP_MAX_COUNT) ? CMP_MAX_COUNT : code;
   endfunction : clamp_count

   // Slot and byte decode of the CPU address
   assign in_block = (addr_i[CMP_BLOCK_MSB:CMP_BLOCK_LSB] ==
                      CMP_BASE_ADDR[CMP_BLOCK_MSB:CMP_BLOCK_LSB]);
   assign slot = addr_i[6:4];
   assign byte_sel = addr_i[3:0];
   assign is_buf = in_block && slot[2];
   assign buf_idx = slot[1:0];
   assign is_mcr0 = (addr_i == CMP_MCR0_ADDR);

   // Write strobes; the receive slot is never a write target
   assign buf_wr = wr_en_i && is_buf && (slot != CMP_SLOT_RX) &&
                   (byte_sel < 4'(CMP_BUF_BYTES));
   assign prio_wr = wr_en_i && is_buf && (slot != CMP_SLOT_RX) &&
                    (byte_sel == CMP_OFS_PRIO);
   assign mcr0_wr = wr_en_i && is_mcr0;

   // Frame lands only when checked good and not held in soft reset
   assign rx_store = rx_done_i && rx_ok_i && !soft_reset_bit_r;
   assign rx_count = clamp_count(rx_dlc_i);

   // Control register 0 writable bits; in soft reset only the soft reset bit takes writes, the rest reload reset values on edges without a write
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         stop_in_wait_r <= CMP_MCR0_RESET[CMP_MCR0_STOP_WAIT_BIT];
         timer_link_enable_r <= CMP_MCR0_RESET[CMP_MCR0_TLINK_BIT];
         sleep_request_r <= CMP_MCR0_RESET[CMP_MCR0_SLP_REQ_BIT];
         soft_reset_bit_r <= CMP_MCR0_RESET[CMP_MCR0_SOFT_RST_BIT];
      end else if (mcr0_wr) begin
         soft_reset_bit_r <= wdata_i[CMP_MCR0_SOFT_RST_BIT];
         if (!soft_reset_bit_r) begin
            stop_in_wait_r <= wdata_i[CMP_MCR0_STOP_WAIT_BIT];
            timer_link_enable_r <= wdata_i[CMP_MCR0_TLINK_BIT];
            sleep_request_r <= wdata_i[CMP_MCR0_SLP_REQ_BIT];
         end
      end else if (soft_reset_bit_r) begin
         stop_in_wait_r <= CMP_MCR0_RESET[CMP_MCR0_STOP_WAIT_BIT];
         timer_link_enable_r <= CMP_MCR0_RESET[CMP_MCR0_TLINK_BIT];
         sleep_request_r <= CMP_MCR0_RESET[CMP_MCR0_SLP_REQ_BIT];
      end
   end

   // Status bits; sync is dropped at once under soft reset
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         bus_synced_r <= CMP_MCR0_RESET[CMP_MCR0_SYNCED_BIT];
         sleep_ack_r <= CMP_MCR0_RESET[CMP_MCR0_SLP_ACK_BIT];
      end else begin
         bus_synced_r <= bus_sync_i && !soft_reset_bit_r && !mcr0_wr_sets_reset();
         sleep_ack_r <= sleep_ack_i && !soft_reset_bit_r;
      end
   end

   // True when the current write turns soft reset on
   function automatic logic mcr0_wr_sets_reset();
      mcr0_wr_sets_reset = mcr0_wr && wdata_i[CMP_MCR0_SOFT_RST_BIT];
   endfunction : mcr0_wr_sets_reset

   // Module clock enable for wait mode
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         module_clk_en_r <= 1'b1;
      end else begin
         module_clk_en_r <= !(stop_in_wait_r && wait_mode_i);
      end
   end

   // Buffer bytes: CPU writes transmit slots, received frames fill slot 4
   always_ff @(posedge clock_i) begin
      if (buf_wr) begin
         buf_mem[buf_idx][byte_sel] <= wdata_i;
      end
      if (rx_store) begin
         if (rx_ide_i) begin
            // Extended layout, MSB of identifier in byte 0 bit 7
            buf_mem[0][CMP_OFS_ID0] <= rx_id_i[28:21];
            buf_mem[0][CMP_OFS_ID1] <= {rx_id_i[20:18], rx_srr_i, 1'b1,
                                        rx_id_i[17:15]};
            buf_mem[0][CMP_OFS_ID2] <= rx_id_i[14:7];
            buf_mem[0][CMP_OFS_ID3] <= {rx_id_i[6:0], rx_rtr_i};
         end else begin
            // Standard layout, low bytes cleared
            buf_mem[0][CMP_OFS_ID0] <= rx_id_i[10:3];
            buf_mem[0][CMP_OFS_ID1] <= {rx_id_i[2:0], rx_rtr_i, 1'b0, 3'h0};
            buf_mem[0][CMP_OFS_ID2] <= 8'h00;
            buf_mem[0][CMP_OFS_ID3] <= 8'h00;
         end
         buf_mem[0][CMP_OFS_LEN] <= {4'h0, rx_dlc_i};
         for (int k = 0; k < CMP_DATA_BYTES; k++) begin
            if (!rx_rtr_i && (4'(k) < rx_count)) begin
               buf_mem[0][4'(k) + CMP_OFS_DATA0] <= rx_data_i[k*8 +: 8];
            end
         end
      end
   end

   // Local priorities, no reset value
   always_ff @(posedge clock_i) begin
      if (prio_wr) begin
         prio_mem[buf_idx - 2'h1] <= wdata_i;
      end
   end

   // Flatten priorities for the selector
   generate
      for (genvar t = 0; t < CMP_NUM_TX; t++) begin : g_prio
         assign prio_flat[t*CMP_PRIO_W +: CMP_PRIO_W] = prio_mem[t];
      end
   endgenerate

   // Arbitration among buffers whose empty flag is clear
   cmp_tx_select #(
      .NUM_TX(CMP_NUM_TX),
      .PRIO_W(CMP_PRIO_W)
   ) u_select (
      .pending_i(~tx_buffer_empty_flag_i),
      .prio_i(prio_flat),
      .win_valid_o(win_valid),
      .win_idx_o(win_idx)
   );

   // Field decode of the winning transmit buffer
   always_comb begin
      w_b0 = buf_mem[win_idx + 2'h1][CMP_OFS_ID0];
      w_b1 = buf_mem[win_idx + 2'h1][CMP_OFS_ID1];
      w_b2 = buf_mem[win_idx + 2'h1][CMP_OFS_ID2];
      w_b3 = buf_mem[win_idx + 2'h1][CMP_OFS_ID3];
      w_len = buf_mem[win_idx + 2'h1][CMP_OFS_LEN];
      w_ide = w_b1[CMP_ID1_IDE_BIT];
      if (w_ide) begin
         w_id = {w_b0, w_b1[7:5], w_b1[2:0], w_b2, w_b3[7:1]};
         w_rtr = w_b3[CMP_ID3_EXT_RTR_BIT];
      end else begin
         w_id = {18'h00000, w_b0, w_b1[7:5]};
         w_rtr = w_b1[CMP_ID1_STD_RTR_BIT];
      end
      w_count = w_rtr ? 4'h0 : clamp_count(w_len[3:0]);
      for (int k = 0; k < CMP_DATA_BYTES; k++) begin
         w_data[k*8 +: 8] = buf_mem[win_idx + 2'h1][4'(k) + CMP_OFS_DATA0];
      end
   end

   // Frame hand-over, latched fresh before every SOF
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         tx_valid_r <= 1'b0;
         tx_buf_r <= 2'h0;
         tx_id_r <= '0;
         tx_ide_r <= 1'b0;
         tx_srr_r <= 1'b0;
         tx_rtr_r <= 1'b0;
         tx_dlc_r <= 4'h0;
         tx_count_r <= 4'h0;
         tx_data_r <= '0;
      end else if (soft_reset_bit_r || mcr0_wr_sets_reset()) begin
         tx_valid_r <= 1'b0;
      end else if (tx_sof_req_i) begin
         tx_valid_r <= win_valid;
         tx_buf_r <= win_idx;
         tx_id_r <= w_id;
         tx_ide_r <= w_ide;
         tx_srr_r <= w_ide ? w_b1[CMP_ID1_SRR_BIT] : 1'b0;
         tx_rtr_r <= w_rtr;
         tx_dlc_r <= w_len[3:0];
         tx_count_r <= w_count;
         tx_data_r <= w_data;
      end else if (tx_end_i) begin
         tx_valid_r <= 1'b0;
      end
   end

   // Read data mux; unmapped and unused bytes read zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (is_mcr0) begin
         rdata_nxt = {2'b00, stop_in_wait_r, bus_synced_r, timer_link_enable_r,
                      sleep_ack_r, sleep_request_r, soft_reset_bit_r};
      end else if (is_buf && (byte_sel < 4'(CMP_BUF_BYTES))) begin
         rdata_nxt = buf_mem[buf_idx][byte_sel];
      end else if (is_buf && (byte_sel == CMP_OFS_PRIO) && (slot != CMP_SLOT_RX)) begin
         rdata_nxt = prio_mem[buf_idx - 2'h1];
      end
   end

   // Registered read answer one cycle after the strobe
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= rd_en_i;
         if (rd_en_i) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   // Outputs straight from flip-flops
   assign rdata_o = rdata_r;
   assign rvalid_o = rvalid_r;
   assign tx_valid_o = tx_valid_r;
   assign tx_buf_o = tx_buf_r;
   assign tx_id_o = tx_id_r;
   assign tx_ide_o = tx_ide_r;
   assign tx_srr_o = tx_srr_r;
   assign tx_rtr_o = tx_rtr_r;
   assign tx_dlc_o = tx_dlc_r;
   assign tx_count_o = tx_count_r;
   assign tx_data_o = tx_data_r;
   assign link_reset_o = soft_reset_bit_r;
   assign module_clk_en_o = module_clk_en_r;
   assign timer_link_enable_o = timer_link_enable_r;
   assign sleep_request_o = sleep_request_r;

endmodule : cmp_prioritizer_top

// file: design/cmp_pkg.sv
// Constants shared by the message storage and transmit selection logic.
// Assumes a byte-wide CPU bus with 16-bit addresses and a 128-byte block.
package cmp_pkg;

   // Bus and block placement
   localparam int unsigned CMP_ADDR_W = 16;
   localparam int unsigned CMP_DATA_W = 8;
   localparam logic [15:0] CMP_BASE_ADDR = 16'h0100;
   localparam logic [15:0] CMP_MCR0_ADDR = 16'h0100;
   localparam int unsigned CMP_BLOCK_MSB = 15;
   localparam int unsigned CMP_BLOCK_LSB = 7;

   // Buffer slots, 16 bytes each, slot index in address bits 6:4
   localparam logic [2:0] CMP_SLOT_RX = 3'h4;
   localparam logic [2:0] CMP_SLOT_TX0 = 3'h5;
   localparam logic [2:0] CMP_SLOT_TX1 = 3'h6;
   localparam logic [2:0] CMP_SLOT_TX2 = 3'h7;
   localparam int unsigned CMP_NUM_BUF = 4;
   localparam int unsigned CMP_NUM_TX = 3;
   localparam int unsigned CMP_BUF_BYTES = 13;

   // Byte positions inside a slot
   localparam logic [3:0] CMP_OFS_ID0 = 4'h0;
   localparam logic [3:0] CMP_OFS_ID1 = 4'h1;
   localparam logic [3:0] CMP_OFS_ID2 = 4'h2;
   localparam logic [3:0] CMP_OFS_ID3 = 4'h3;
   localparam logic [3:0] CMP_OFS_DATA0 = 4'h4;
   localparam logic [3:0] CMP_OFS_LEN = 4'hC;
   localparam logic [3:0] CMP_OFS_PRIO = 4'hD;
   localparam int unsigned CMP_DATA_BYTES = 8;
   localparam logic [3:0] CMP_MAX_COUNT = 4'h8;

   // Identifier byte 1 and byte 3 field positions, identifier widths
   localparam int unsigned CMP_ID1_SRR_BIT = 4;
   localparam int unsigned CMP_ID1_IDE_BIT = 3;
   localparam int unsigned CMP_ID1_STD_RTR_BIT = 4;
   localparam int unsigned CMP_ID3_EXT_RTR_BIT = 0;
   localparam int unsigned CMP_STD_ID_W = 11;
   localparam int unsigned CMP_EXT_ID_W = 29;

   // Module control register 0
   localparam logic [7:0] CMP_MCR0_RESET = 8'h21;
   localparam int unsigned CMP_MCR0_STOP_WAIT_BIT = 5;
   localparam int unsigned CMP_MCR0_SYNCED_BIT = 4;
   localparam int unsigned CMP_MCR0_TLINK_BIT = 3;
   localparam int unsigned CMP_MCR0_SLP_ACK_BIT = 2;
   localparam int unsigned CMP_MCR0_SLP_REQ_BIT = 1;
   localparam int unsigned CMP_MCR0_SOFT_RST_BIT = 0;

   // Local priority width
   localparam int unsigned CMP_PRIO_W = 8;

endpackage : cmp_pkg

// file: design/cmp_tx_select.sv
// Picks the pending transmit buffer with the smallest local priority.
// Assumes pending bits and priorities are stable while the result is sampled.
`timescale 1ns/1ps
module cmp_tx_select #(
   parameter int unsigned NUM_TX = cmp_pkg::CMP_NUM_TX,
   parameter int unsigned PRIO_W = cmp_pkg::CMP_PRIO_W
) (
   input wire logic [NUM_TX-1:0] pending_i,
   input wire logic [NUM_TX*PRIO_W-1:0] prio_i,
   output logic win_valid_o,
   output logic [1:0] win_idx_o
);
   import cmp_pkg::*;

   // Index output is two bits wide
   if (NUM_TX < 1 || NUM_TX > 4 || PRIO_W < 1) begin : g_bad_param
      $error("cmp_tx_select: unsupported NUM_TX or PRIO_W");
   end

   // Linear scan; strict less keeps the lower index on a tie
   always_comb begin
      logic [PRIO_W-1:0] best;
      best = '1;
      win_valid_o = 1'b0;
      win_idx_o = 2'h0;
      for (int i = 0; i < NUM_TX; i++) begin
         if (pending_i[i] && (!win_valid_o || prio_i[i*PRIO_W +: PRIO_W] < best)) begin
            best = prio_i[i*PRIO_W +: PRIO_W];
            win_valid_o = 1'b1;
            win_idx_o = 2'(i);
         end
      end
   end

endmodule : cmp_tx_select

// file: tb/cmp_prioritizer_asserts.sv
// Checker for the buffer and transmit selection top.
// Sees only the top's ports; bound to every instance of the top.
`timescale 1ns/1ps
module cmp_prioritizer_asserts (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [15:0] addr_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [7:0] wdata_i,
   input wire logic rvalid_o,
   input wire logic [2:0] tx_buffer_empty_flag_i,
   input wire logic tx_sof_req_i,
   input wire logic tx_end_i,
   input wire logic tx_valid_o,
   input wire logic [1:0] tx_buf_o,
   input wire logic [28:0] tx_id_o,
   input wire logic tx_ide_o,
   input wire logic tx_srr_o,
   input wire logic tx_rtr_o,
   input wire logic [3:0] tx_dlc_o,
   input wire logic [3:0] tx_count_o,
   input wire logic wait_mode_i,
   input wire logic link_reset_o,
   input wire logic module_clk_en_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   logic sr_wr;
   logic take;
   logic [2:0] flags_q;
   // Soft reset write, and a start request that is taken
   assign sr_wr = wr_en_i && addr_i == 16'h0100 && wdata_i[0];
   assign take = tx_sof_req_i && !link_reset_o && !sr_wr;
   // Flags as seen at the request edge
   always_ff @(posedge clock_i) begin
      flags_q <= tx_buffer_empty_flag_i;
   end
   read_answer_a: assert property (rd_en_i |=> rvalid_o)
      else $error("read not answered");
   no_stray_read_a: assert property (!rd_en_i |=> !rvalid_o)
      else $error("answer without read");
   none_pending_a: assert property (take && &tx_buffer_empty_flag_i |=> !tx_valid_o)
      else $error("frame picked with all buffers empty");
   winner_pending_a: assert property (take && !(&tx_buffer_empty_flag_i) |=>
      tx_valid_o && tx_buf_o != 2'h3 && !flags_q[tx_buf_o])
      else $error("winner is not a pending buffer");
   end_drops_a: assert property (tx_end_i && !tx_sof_req_i |=> !tx_valid_o)
      else $error("frame not dropped at end");
   soft_abort_a: assert property (sr_wr |=> (link_reset_o && !tx_valid_o) [*2])
      else $error("soft reset did not abort");
   rtr_no_data_a: assert property (tx_valid_o && tx_rtr_o |-> tx_count_o == 4'h0)
      else $error("remote frame carries data");
   count_follows_a: assert property (tx_valid_o && !tx_rtr_o |->
      tx_count_o == (tx_dlc_o > 4'h8 ? 4'h8 : tx_dlc_o))
      else $error("byte count does not follow length");
   std_layout_a: assert property (tx_valid_o && !tx_ide_o |->
      tx_id_o[28:11] == 18'h0 && !tx_srr_o)
      else $error("standard frame has extended bits");
   wait_run_a: assert property (!wait_mode_i |=> module_clk_en_o)
      else $error("clock gated outside wait");
   cover property (take && !(&tx_buffer_empty_flag_i));
   cover property (sr_wr);
   cover property (tx_valid_o && tx_rtr_o);
   cover property (tx_valid_o && tx_ide_o);
endmodule : cmp_prioritizer_asserts

bind cmp_prioritizer_top cmp_prioritizer_asserts i_chk (.clock_i, .reset_i, .addr_i, .wr_en_i,
   .rd_en_i, .wdata_i, .rvalid_o, .tx_buffer_empty_flag_i, .tx_sof_req_i, .tx_end_i, .tx_valid_o,
   .tx_buf_o, .tx_id_o, .tx_ide_o, .tx_srr_o, .tx_rtr_o, .tx_dlc_o, .tx_count_o, .wait_mode_i,
   .link_reset_o, .module_clk_en_o);

// file: tb/cmp_engine_model.sv
// Bit engine stand-in: asks for frames and hands over received ones.
// Assumes its outputs feed the top; changes just after rising edges.
`timescale 1ns/1ps
module cmp_engine_model (
   input wire logic clock_i,
   output logic tx_sof_req_o,
   output logic tx_end_o,
   output logic rx_done_o,
   output logic rx_ok_o,
   output logic [44:0] rx_f_o,
   output logic [63:0] rx_data_o
);
   // Quiet strobes from time zero
   initial begin
      tx_sof_req_o = 1'b0;
      tx_end_o = 1'b0;
      rx_done_o = 1'b0;
      rx_ok_o = 1'b0;
      rx_f_o = '0;
      rx_data_o = '0;
   end
   // One-edge pulse on the start or the end strobe
   task automatic pulse(input logic is_end);
      @(posedge clock_i);
      #2;
      if (is_end) tx_end_o = 1'b1;
      else tx_sof_req_o = 1'b1;
      @(posedge clock_i);
      #2;
      tx_end_o = 1'b0;
      tx_sof_req_o = 1'b0;
   endtask : pulse
   // Finished frame, fields scrambled once handed over
   task automatic frame(input logic [44:0] f, input logic [63:0] d, input logic ok);
      @(posedge clock_i);
      #2;
      rx_f_o = f;
      rx_data_o = d;
      rx_ok_o = ok;
      rx_done_o = 1'b1;
      @(posedge clock_i);
      #2;
      rx_done_o = 1'b0;
      rx_ok_o = ~ok;
      rx_f_o = ~f;
      rx_data_o = ~d;
   endtask : frame
endmodule : cmp_engine_model

// file: tb/testbench.sv
// Self-checking bench for the buffer and transmit selection top.
// Assumes the engine model and the bound checker from this folder.
`timescale 1ns/1ps
module testbench;
   import cmp_pkg::*;
   logic clock_i, reset_i, wr_en_i, rd_en_i, rvalid_o, sof, fin, tx_valid_o, tx_ide_o;
   logic tx_srr_o, tx_rtr_o, rx_done_i, rx_ok_i, bus_sync_i, sleep_ack_i, wait_mode_i;
   logic link_reset_o, module_clk_en_o, timer_link_enable_o, sleep_request_o;
   logic stop_in_wait, tlnk, sleep_request, sft;
   logic [15:0] addr_i;
   logic [7:0] wdata_i, rdata_o, d;
   logic [2:0] flags;
   logic [1:0] tx_buf_o;
   logic [28:0] tx_id_o;
   logic [44:0] rxf;
   logic [3:0] tx_dlc_o, tx_count_o;
   logic [63:0] tx_data_o, rx_data_i;
   logic [7:0] mem [0:127];
   int n_mismatch = 0;
   int compares = 0;
   cmp_prioritizer_top i_dut (.clock_i, .reset_i, .addr_i, .wr_en_i, .rd_en_i, .wdata_i,
      .rdata_o, .rvalid_o, .tx_buffer_empty_flag_i(flags), .tx_sof_req_i(sof),
      .tx_end_i(fin), .tx_valid_o, .tx_buf_o, .tx_id_o, .tx_ide_o, .tx_srr_o, .tx_rtr_o,
      .tx_dlc_o, .tx_count_o, .tx_data_o, .rx_done_i, .rx_ok_i, .rx_id_i(rxf[44:16]),
      .rx_ide_i(rxf[15]), .rx_srr_i(rxf[14]), .rx_rtr_i(rxf[13]), .rx_dlc_i(rxf[12:9]),
      .rx_data_i, .bus_sync_i, .sleep_ack_i, .wait_mode_i, .link_reset_o, .module_clk_en_o,
      .timer_link_enable_o, .sleep_request_o);
   cmp_engine_model i_eng (.clock_i, .tx_sof_req_o(sof), .tx_end_o(fin), .rx_done_o(rx_done_i),
      .rx_ok_o(rx_ok_i), .rx_f_o(rxf), .rx_data_o(rx_data_i));
   // Clock, 100 ns period
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   // One byte cycle; request held over exactly one edge
   task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] v);
      @(posedge clock_i);
      #2;
      addr_i = a;
      wdata_i = v;
      wr_en_i = w;
      rd_en_i = ~w;
      @(posedge clock_i);
      #2;
      wr_en_i = 1'b0;
      rd_en_i = 1'b0;
   endtask : cyc
   // Write, tracked in the model; receive slot and holes ignore it
   task automatic mwr(input logic [15:0] a, input logic [7:0] v);
      cyc(a, 1'b1, v);
      if (a == CMP_MCR0_ADDR) begin
         if (!sft) {stop_in_wait, tlnk, sleep_request} = {v[5], v[3], v[1]};
         sft = v[0];
         if (sft) {stop_in_wait, tlnk, sleep_request} = 3'b100;
      end else if (a[6:4] >= 3'h5 && a[3:0] <= CMP_OFS_PRIO) mem[a[6:0]] = v;
   endtask : mwr
   task automatic mrd(input logic [15:0] a);
      logic [7:0] e;
      e = 8'h00;
      if (a == CMP_MCR0_ADDR) e = {2'b00, stop_in_wait, bus_sync_i & ~sft, tlnk, sleep_ack_i & ~sft, sleep_request, sft};
      else if (a[6:4] >= 3'h4 && a[3:0] <= CMP_OFS_LEN) e = mem[a[6:0]];
      else if (a[6:4] >= 3'h5 && a[3:0] == CMP_OFS_PRIO) e = mem[a[6:0]];
      cyc(a, 1'b0, 8'h00);
      chk("rvalid", rvalid_o, 1'b1);
      chk("rdata", rdata_o, e);
   endtask : mrd
   // Start a frame, compare the pick and its fields, then end it
   task automatic tx_trial();
      logic [7:0] b1, b3, best;
      logic [28:0] id;
      logic [63:0] dat;
      logic [3:0] dl;
      int w, s;
      w = -1;
      best = 8'hFF;
      for (int i = 2; i >= 0; i--) if (!flags[i] && mem[93 + 16 * i] <= best) begin
         w = i;
         best = mem[93 + 16 * i];
      end
      i_eng.pulse(1'b0);
      if (w < 0) chk("tx_valid", tx_valid_o, 1'b0);
      else begin
         s = 80 + 16 * w;
         b1 = mem[s + 1];
         b3 = mem[s + 3];
         dl = mem[s + 12][3:0];
         id = b1[3] ? {mem[s], b1[7:5], b1[2:0], mem[s + 2], b3[7:1]} : {18'h0, mem[s], b1[7:5]};
         for (int k = 0; k < 8; k++) dat[8 * k +: 8] = mem[s + 4 + k];
         b3[1] = b1[3] ? b3[0] : b1[4];
         chk("tx", {tx_valid_o, tx_buf_o, tx_id_o, tx_ide_o, tx_srr_o, tx_rtr_o, tx_dlc_o, tx_count_o},
            {1'b1, 2'(w), id, b1[3], b1[3] & b1[4], b3[1], dl,
            b3[1] ? 4'h0 : (dl > 4'h8 ? 4'h8 : dl)});
         chk("tx_data", tx_data_o, dat);
      end
      i_eng.pulse(1'b1);
      chk("tx_end", tx_valid_o, 1'b0);
   endtask : tx_trial
   // Deliver a random frame, model the store, poke and read the slot
   task automatic rx_trial(input logic ok);
      logic [28:0] id;
      logic [3:0] dl, cnt;
      logic [63:0] dat;
      logic ide, srr, rtr;
      {id, ide, srr, rtr, dl} = 36'({$urandom, $urandom});
      dat = {$urandom, $urandom};
      if (!ide) id[28:11] = 18'h0;
      i_eng.frame({id, ide, srr, rtr, dl, 9'h0}, dat, ok);
      if (ok && !sft) begin
         cnt = rtr ? 4'h0 : (dl > 4'h8 ? 4'h8 : dl);
         mem[64] = ide ? id[28:21] : id[10:3];
         mem[65] = ide ? {id[20:18], srr, 1'b1, id[17:15]} : {id[2:0], rtr, 4'h0};
         mem[66] = ide ? id[14:7] : 8'h00;
         mem[67] = ide ? {id[6:0], rtr} : 8'h00;
         mem[76] = {4'h0, dl};
         for (int k = 0; k < 8; k++) if (k < cnt) mem[68 + k] = dat[8 * k +: 8];
      end
      mwr(16'h0140 + 16'($urandom % 13), 8'($urandom));
      for (int a = 0; a < 16; a++) mrd(16'h0140 + 16'(a));
   endtask : rx_trial
   initial begin
      repeat (100000) @(posedge clock_i);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      {reset_i, wr_en_i, rd_en_i, addr_i, wdata_i, flags} = {3'b100, 27'h0};
      {bus_sync_i, sleep_ack_i, wait_mode_i} = 3'b100;
      {stop_in_wait, tlnk, sleep_request, sft} = 4'b1001;
      void'($urandom(31249));
      repeat (12) @(posedge clock_i);
      #2;
      reset_i = 1'b0;
      mrd(CMP_MCR0_ADDR);
      chk("ctl", {link_reset_o, module_clk_en_o, timer_link_enable_o, sleep_request_o},
         4'hC);
      i_eng.pulse(1'b0);
      chk("sof_refused", tx_valid_o, 1'b0);
      $display("test reset done");
      mwr(CMP_MCR0_ADDR, 8'hFE);
      sleep_ack_i = 1'b1;
      mrd(CMP_MCR0_ADDR);
      mwr(CMP_MCR0_ADDR, 8'h0A);
      mrd(CMP_MCR0_ADDR);
      wait_mode_i = 1'b1;
      mwr(CMP_MCR0_ADDR, 8'h2A);
      chk("ctl", {link_reset_o, timer_link_enable_o, sleep_request_o}, 3'h3);
      @(posedge clock_i);
      #2;
      chk("clk_stop", module_clk_en_o, 1'b0);
      wait_mode_i = 1'b0;
      repeat (2) @(posedge clock_i);
      #2;
      chk("clk_run", module_clk_en_o, 1'b1);
      $display("test control done");
      for (int a = 80; a < 128; a++) begin
         d = 8'($urandom);
         if (a % 16 == 1 && d[3]) d[4] = 1'b1;
         if (a % 16 == 12) d[7:4] = 4'h0;
         mwr(16'h0100 + 16'(a), d);
      end
      for (int a = 0; a < 128; a++) mrd(16'h0100 + 16'(a));
      $display("test map done");
      for (int t = 0; t < 60; t++) begin
         mwr(16'h015D + 16'(16 * ($urandom % 3)), 8'($urandom % 4));
         mwr(16'h015C + 16'(16 * ($urandom % 3)), 8'($urandom % 16));
         mwr(16'h0153 + 16'(16 * ($urandom % 3)), 8'($urandom));
         flags = 3'($urandom);
         tx_trial();
      end
      $display("test select done");
      flags = 3'h0;
      i_eng.pulse(1'b0);
      mwr(CMP_MCR0_ADDR, 8'h01);
      chk("abort", {tx_valid_o, link_reset_o}, 2'h1);
      mrd(CMP_MCR0_ADDR);
      rx_trial(1'b1);
      mwr(CMP_MCR0_ADDR, 8'h00);
      $display("test abort done");
      for (int t = 0; t < 30; t++) rx_trial(($urandom % 4) != 0);
      $display("test receive done");
      give_verdict();
   end
endmodule : testbench
